// >>> hdl/bdm_pkg.sv
package bdm_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int          BDM_BANKS       = 32;
   localparam int          BDM_BANK_BYTES  = 128;
   localparam int          BDM_ADDR_W      = 12;
   localparam int          BDM_BANK_W      = 5;
   localparam int          BDM_OFS_W       = 7;
   localparam int          BDM_CORE_REGS   = 12;
   localparam int          BDM_SFR_SLOTS   = 20;
   localparam int          BDM_GPR_BYTES   = 80;
   localparam int          BDM_COMMON_BYTES = 16;

   // ----------------------------------------------------------------
   // in-bank offsets
   // ----------------------------------------------------------------
   localparam logic [6:0]  BDM_OFS_IND0    = 7'h00;
   localparam logic [6:0]  BDM_OFS_IND1    = 7'h01;
   localparam logic [6:0]  BDM_OFS_PCL     = 7'h02;
   localparam logic [6:0]  BDM_OFS_FLAGS   = 7'h03;
   localparam logic [6:0]  BDM_OFS_P0L     = 7'h04;
   localparam logic [6:0]  BDM_OFS_P0H     = 7'h05;
   localparam logic [6:0]  BDM_OFS_P1L     = 7'h06;
   localparam logic [6:0]  BDM_OFS_P1H     = 7'h07;
   localparam logic [6:0]  BDM_OFS_BANK    = 7'h08;
   localparam logic [6:0]  BDM_OFS_WORKING_ACCUMULATOR    = 7'h09;
   localparam logic [6:0]  BDM_OFS_PROGRAM_COUNTER_HIGH_LATCH  = 7'h0a;
   localparam logic [6:0]  BDM_OFS_INTCTL  = 7'h0b;
   localparam logic [6:0]  BDM_OFS_SFR_LO  = 7'h0c;
   localparam logic [6:0]  BDM_OFS_GPR_LO  = 7'h20;
   localparam logic [6:0]  BDM_OFS_CMN_LO  = 7'h70;

   // ----------------------------------------------------------------
   // flag register fields and reset values
   // ----------------------------------------------------------------
   localparam int          BDM_FLG_C       = 0;
   localparam int          BDM_FLG_DC      = 1;
   localparam int          BDM_FLG_Z       = 2;
   localparam int          BDM_FLG_PD      = 3;
   localparam int          BDM_FLG_TO      = 4;
   localparam logic [7:0]  BDM_FLG_ALU_MSK = 8'h07;
   localparam logic [7:0]  BDM_FLG_RST_MSK = 8'h18;
   localparam logic [7:0]  BDM_FLG_UP_MSK  = 8'he0;
   localparam logic [7:0]  BDM_FLAGS_RST   = 8'h18;
   localparam logic [7:0]  BDM_REG_RST     = 8'h00;
   localparam int          BDM_GPR_BANKS   = 4;

   // ----------------------------------------------------------------
   // access from the core
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      BDM_MODE_DIRECT = 3'b001,
      BDM_MODE_PTR0   = 3'b010,
      BDM_MODE_PTR1   = 3'b100
   } bdm_mode_e;

   typedef struct packed {
      logic        rd;
      logic        wr;
      bdm_mode_e   mode;
      logic [6:0]  ofs;
      logic [7:0]  wdata;
      logic        clr_file;
      logic        alu_flags;
      logic [2:0]  alu_zdc_c;
   } bdm_req_s;

   typedef struct packed {
      logic [11:0] addr;
      logic        is_core;
      logic        is_gpr;
      logic        is_common;
      logic [6:0]  ofs;
   } bdm_dec_s;

endpackage

// >>> hdl/bdm_addr_dec.sv
`timescale 1ns/1ps
module bdm_addr_dec
   import bdm_pkg::*;
(
   // address in
   input  wire logic [11:0] addr_i,
   // decoded fields
   output bdm_dec_s         dec_o
);

   always_comb begin
      dec_o           = '0;
      dec_o.addr      = addr_i;
      dec_o.ofs       = addr_i[BDM_OFS_W-1:0];
      dec_o.is_core   = (addr_i[6:0] < BDM_OFS_SFR_LO);
      dec_o.is_common = (addr_i[6:0] >= BDM_OFS_CMN_LO);
      // banked ram only in low banks
      dec_o.is_gpr    = (addr_i[6:0] >= BDM_OFS_GPR_LO) && !dec_o.is_common
                        && (addr_i[11:7] < 5'(BDM_GPR_BANKS));
   end

endmodule

// >>> hdl/bdm_flags.sv
`timescale 1ns/1ps
module bdm_flags
   import bdm_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       resetn_i,
   // update controls
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       clr_file_i,
   input  wire logic       alu_upd_i,
   input  wire logic [2:0] alu_zdc_c_i,
   input  wire logic       rst_upd_i,
   input  wire logic [1:0] rst_to_pd_i,
   // flag value
   output logic      [7:0] flags_o
);

   logic [7:0] flags_nxt;

   // merge write, alu and reset-status sources
   always_comb begin
      flags_nxt = flags_o;
      if (wr_i) begin
         flags_nxt = (wdata_i & ~BDM_FLG_RST_MSK) | (flags_o & BDM_FLG_RST_MSK);
      end
      // clear file clears top, sets zero
      if (clr_file_i) begin
         flags_nxt = (flags_o & ~BDM_FLG_UP_MSK);
         flags_nxt[BDM_FLG_Z] = 1'b1;
      end
      // carry bits carry borrow in subtract
      if (alu_upd_i && !clr_file_i) begin
         flags_nxt[BDM_FLG_Z]  = alu_zdc_c_i[2];
         flags_nxt[BDM_FLG_DC] = alu_zdc_c_i[1];
         flags_nxt[BDM_FLG_C]  = alu_zdc_c_i[0];
      end
      if (rst_upd_i) begin
         flags_nxt[BDM_FLG_TO] = rst_to_pd_i[1];
         flags_nxt[BDM_FLG_PD] = rst_to_pd_i[0];
      end
   end

   // flag storage
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flags_o <= BDM_FLAGS_RST;
      end else begin
         flags_o <= flags_nxt;
      end
   end

endmodule

// >>> hdl/bdm_core.sv
`timescale 1ns/1ps
module bdm_core
   import bdm_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       resetn_i,
   // core request
   input  bdm_req_s        req_i,
   // reset status capture
   input  wire logic       rst_upd_i,
   input  wire logic [1:0] rst_to_pd_i,
   // special function window
   input  wire logic [7:0] sfr_rdata_i,
   output logic            sfr_wr_o,
   output logic            sfr_rd_o,
   output logic      [11:0] sfr_addr_o,
   output logic      [7:0] sfr_wdata_o,
   // answer
   output logic      [7:0] rdata_o,
   output logic            rvalid_o,
   output logic      [7:0] bank_o,
   output logic      [7:0] working_accumulator_o,
   output logic      [7:0] flags_o
);

   // ----------------------------------------------------------------
   // in-bank map, same in all thirty-two banks
   // ----------------------------------------------------------------
   // 0x00..0x0b  core registers, shared by every bank
   //             0x00/0x01 indirect ports, nothing stored there
   //             0x02 program counter low
   //             0x03 alu and reset flags, kept in bdm_flags
   //             0x04..0x07 two sixteen-bit pointers, low byte first
   //             0x08 bank selector, five live bits
   //             0x09 working accumulator
   //             0x0a program counter high latch, seven live bits
   //             0x0b interrupt control, a plain byte here
   // 0x0c..0x1f  special function window, passed to the peripherals
   // 0x20..0x6f  general purpose ram, backed in the low banks only
   // 0x70..0x7f  common ram, one physical copy for all banks
   //
   // full address is bank in bits 11:7, offset in bits 6:0
   // pointers reach the same map through their low twelve bits

   // ----------------------------------------------------------------
   // limits a user must know
   // ----------------------------------------------------------------
   // one request per cycle; rd, wr and clear file are pulses
   // a read in the same cycle as a write sees the old contents
   // ram holds no reset value, so software must set it before use
   // timeout and powerdown move only on reset-status updates
   // bank selector keeps five bits, the upper three read as zero
   // high latch keeps seven bits, bit seven reads as zero
   // window strobes trail the request by one cycle
   // peripheral read data is taken in the request cycle itself

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // pointers kept as byte pairs so each half is a plain register
   // backed ram: four banks of 80 bytes; common ram: 16 bytes
   logic [7:0]  pcl_r;
   logic [7:0]  ptr0_r [2];
   logic [7:0]  ptr1_r [2];
   logic [7:0]  bank_r;
   logic [7:0]  working_accumulator_r;
   logic [7:0]  program_counter_high_latch_r;
   logic [7:0]  intctl_r;
   logic [7:0]  gpr_mem [BDM_GPR_BANKS*BDM_GPR_BYTES];
   logic [7:0]  cmn_mem [BDM_COMMON_BYTES];
   logic [7:0]  flags_w;

   // ----------------------------------------------------------------
   // address formation
   // ----------------------------------------------------------------
   logic [11:0] addr;
   logic [15:0] ptr_sel;
   bdm_dec_s    dec;
   logic        acc;
   logic        wr_hit;
   logic        flag_wr;
   logic        flag_clr;
   logic [8:0]  gpr_idx;
   logic [3:0]  cmn_idx;
   logic        ptr_via_ind;

   // direct mode: bank selector in bits 11:7, operand in bits 6:0
   // pointer modes: low twelve pointer bits taken as they stand,
   // the bank selector plays no part; the upper four bits are kept
   // for software but never decoded here
   // pick direct or pointer path
   always_comb begin
      ptr_sel = 16'h0000;
      unique case (req_i.mode)
         BDM_MODE_PTR0: ptr_sel = {ptr0_r[1], ptr0_r[0]};
         BDM_MODE_PTR1: ptr_sel = {ptr1_r[1], ptr1_r[0]};
         BDM_MODE_DIRECT: ptr_sel = 16'h0000;
         default: ptr_sel = 16'h0000;
      endcase
      if (req_i.mode == BDM_MODE_DIRECT) begin
         addr = {bank_r[BDM_BANK_W-1:0], req_i.ofs};
      end else begin
         addr = ptr_sel[11:0];
      end
   end

   bdm_addr_dec u_dec (
      .addr_i (addr),
      .dec_o  (dec)
   );

   assign acc         = req_i.rd | req_i.wr | req_i.clr_file;
   assign wr_hit      = req_i.wr | req_i.clr_file;
   // pointer landing on an indirect port is not followed again
   assign ptr_via_ind = dec.is_core && (dec.ofs == BDM_OFS_IND0 || dec.ofs == BDM_OFS_IND1);
   assign flag_wr     = req_i.wr && !req_i.clr_file && dec.is_core && dec.ofs == BDM_OFS_FLAGS;
   assign flag_clr    = req_i.clr_file && dec.is_core && dec.ofs == BDM_OFS_FLAGS;
   // the four backed banks are packed densely, 80 bytes apart, so no
   // storage is spent on core, window or common offsets; nine bits
   // cover the 320 entries, larger indices are never used
   // bank times the 80 backed ram bytes per bank
   assign gpr_idx     = 9'(dec.addr[11:7] * BDM_GPR_BYTES)
                        + 9'(dec.ofs - BDM_OFS_GPR_LO);
   assign cmn_idx     = dec.ofs[3:0];

   // ----------------------------------------------------------------
   // flag register
   // ----------------------------------------------------------------
   // flag merging lives in its own module so the write rules stay in
   // one place; alu and reset-status inputs bypass the address decode
   // flags_w is the live value, flags_o trails it by one cycle
   bdm_flags u_flags (
      .core_clk_i  (core_clk_i),
      .resetn_i    (resetn_i),
      .wr_i        (flag_wr),
      .wdata_i     (req_i.wdata),
      .clr_file_i  (flag_clr),
      .alu_upd_i   (req_i.alu_flags),
      .alu_zdc_c_i (req_i.alu_zdc_c),
      .rst_upd_i   (rst_upd_i),
      .rst_to_pd_i (rst_to_pd_i),
      .flags_o     (flags_w)
   );

   // ----------------------------------------------------------------
   // core register writes
   // ----------------------------------------------------------------
   // writes land on the edge that samples the request
   // clear file writes zero to any target; the flags take their own
   // clear-file rule inside bdm_flags instead
   logic [7:0] wval;
   assign wval = req_i.clr_file ? BDM_REG_RST : req_i.wdata;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pcl_r     <= BDM_REG_RST;
         ptr0_r[0] <= BDM_REG_RST;
         ptr0_r[1] <= BDM_REG_RST;
         ptr1_r[0] <= BDM_REG_RST;
         ptr1_r[1] <= BDM_REG_RST;
         bank_r    <= BDM_REG_RST;
         working_accumulator_r    <= BDM_REG_RST;
         program_counter_high_latch_r  <= BDM_REG_RST;
         intctl_r  <= BDM_REG_RST;
      end else if (wr_hit && dec.is_core) begin
         unique case (dec.ofs)
            BDM_OFS_PCL:    pcl_r     <= wval;
            BDM_OFS_P0L:    ptr0_r[0] <= wval;
            BDM_OFS_P0H:    ptr0_r[1] <= wval;
            BDM_OFS_P1L:    ptr1_r[0] <= wval;
            BDM_OFS_P1H:    ptr1_r[1] <= wval;
            // only five bank bits exist
            BDM_OFS_BANK:   bank_r    <= {3'h0, wval[4:0]};
            BDM_OFS_WORKING_ACCUMULATOR:   working_accumulator_r    <= wval;
            BDM_OFS_PROGRAM_COUNTER_HIGH_LATCH: program_counter_high_latch_r  <= {1'b0, wval[6:0]};
            BDM_OFS_INTCTL: intctl_r  <= wval;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // ram writes
   // ----------------------------------------------------------------
   // ram carries no reset; contents are undefined at power-up
   // banks four and up have no backing ram: writes there vanish and
   // reads fall through to zero in the read mux
   always_ff @(posedge core_clk_i) begin
      if (wr_hit && dec.is_gpr) begin
         gpr_mem[gpr_idx] <= wval;
      end
   end

   // one physical copy for all banks
   always_ff @(posedge core_clk_i) begin
      if (wr_hit && dec.is_common) begin
         cmn_mem[cmn_idx] <= wval;
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   logic [7:0] rd_nxt;
   logic       sfr_hit;
   assign sfr_hit = !dec.is_core && !dec.is_gpr && !dec.is_common
                    && dec.ofs < BDM_OFS_GPR_LO;

   // priority: core, banked ram, common ram, peripheral window
   // the window answers combinationally, so the peripheral side must
   // hold its data stable for the whole request cycle
   // a pointer aimed at an indirect port would loop, so it reads zero;
   // unlisted core offsets fall to the default zero as well
   // holes and indirect self-loops read zero
   always_comb begin
      rd_nxt = 8'h00;
      if (dec.is_core) begin
         unique case (dec.ofs)
            BDM_OFS_PCL:    rd_nxt = pcl_r;
            BDM_OFS_FLAGS:  rd_nxt = flags_w;
            BDM_OFS_P0L:    rd_nxt = ptr0_r[0];
            BDM_OFS_P0H:    rd_nxt = ptr0_r[1];
            BDM_OFS_P1L:    rd_nxt = ptr1_r[0];
            BDM_OFS_P1H:    rd_nxt = ptr1_r[1];
            BDM_OFS_BANK:   rd_nxt = bank_r;
            BDM_OFS_WORKING_ACCUMULATOR:   rd_nxt = working_accumulator_r;
            BDM_OFS_PROGRAM_COUNTER_HIGH_LATCH: rd_nxt = program_counter_high_latch_r;
            BDM_OFS_INTCTL: rd_nxt = intctl_r;
            default:        rd_nxt = 8'h00;
         endcase
      end else if (dec.is_gpr) begin
         rd_nxt = gpr_mem[gpr_idx];
      end else if (dec.is_common) begin
         rd_nxt = cmn_mem[cmn_idx];
      end else if (sfr_hit) begin
         rd_nxt = sfr_rdata_i;
      end
      if (ptr_via_ind) begin
         rd_nxt = 8'h00;
      end
   end

   // every output is a flop, so the mirrors trail internal state by
   // one cycle; rdata holds its last value until the next read
   // registered answer and mirrors
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o  <= 8'h00;
         rvalid_o <= 1'b0;
         bank_o   <= BDM_REG_RST;
         working_accumulator_o   <= BDM_REG_RST;
         flags_o  <= BDM_FLAGS_RST;
      end else begin
         rvalid_o <= req_i.rd;
         if (req_i.rd) begin
            rdata_o <= rd_nxt;
         end
         bank_o  <= bank_r;
         working_accumulator_o  <= working_accumulator_r;
         flags_o <= flags_w;
      end
   end

   // address and data flop every cycle and only the strobes qualify
   // them, which keeps the enable logic off the wide paths
   // special function strobes, registered
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sfr_wr_o    <= 1'b0;
         sfr_rd_o    <= 1'b0;
         sfr_addr_o  <= 12'h000;
         sfr_wdata_o <= 8'h00;
      end else begin
         sfr_wr_o    <= acc && wr_hit && sfr_hit;
         sfr_rd_o    <= req_i.rd && sfr_hit;
         sfr_addr_o  <= dec.addr;
         sfr_wdata_o <= wval;
      end
   end

endmodule

// >>> sim/bdm_core_chk.sv
`timescale 1ns/1ps
module bdm_core_chk
   import bdm_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   // requests
   input  bdm_req_s         req_i,
   input  wire logic        rst_upd_i,
   // answers
   input  wire logic        sfr_wr_o,
   input  wire logic        sfr_rd_o,
   input  wire logic [11:0] sfr_addr_o,
   input  wire logic [7:0]  sfr_wdata_o,
   input  wire logic        rvalid_o,
   input  wire logic [7:0]  bank_o,
   input  wire logic [7:0]  flags_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   // direct hits on the peripheral window and on the flag register
   logic sfr_hit;
   logic flg_hit;
   assign sfr_hit = req_i.mode == BDM_MODE_DIRECT && req_i.ofs >= BDM_OFS_SFR_LO
                    && req_i.ofs < BDM_OFS_GPR_LO;
   assign flg_hit = req_i.mode == BDM_MODE_DIRECT && req_i.ofs == BDM_OFS_FLAGS;
   sequence s_clr;
      req_i.clr_file && flg_hit;
   endsequence
   sequence s_zero_top;
      flags_o[2] && flags_o[7:5] == 3'h0;
   endsequence
   chk_read_valid: assert property (req_i.rd |=> rvalid_o)
      else $error("read not answered");
   chk_valid_cause: assert property (rvalid_o |-> $past(req_i.rd))
      else $error("answer without read");
   chk_sfr_read: assert property (req_i.rd && sfr_hit |=> sfr_rd_o
      && sfr_addr_o[6:0] == $past(req_i.ofs)) else $error("window read lost");
   chk_sfr_write: assert property (req_i.wr && sfr_hit |=> sfr_wr_o
      && sfr_wdata_o == $past(req_i.wdata)) else $error("window write lost");
   chk_sfr_cause: assert property (sfr_wr_o |-> $past(req_i.wr || req_i.clr_file))
      else $error("window write without request");
   chk_bank_bits: assert property (bank_o[7:5] == 3'h0)
      else $error("bank wider than five bits");
   chk_clr_flags: assert property (s_clr |=> ##1 s_zero_top)
      else $error("clear file on flags wrong");
   chk_alu_load: assert property (req_i.wr && flg_hit && req_i.alu_flags && !req_i.clr_file
      |=> ##1 flags_o[2:0] == $past(req_i.alu_zdc_c, 2)) else $error("alu flags not loaded");
   chk_tp_locked: assert property ($changed(flags_o[4:3])
      |-> $past(rst_upd_i) || $past(rst_upd_i, 2)) else $error("reset status moved");
endmodule
bind bdm_core bdm_core_chk u_bdm_core_chk (.core_clk_i, .resetn_i, .req_i, .rst_upd_i,
   .sfr_wr_o, .sfr_rd_o, .sfr_addr_o, .sfr_wdata_o, .rvalid_o, .bank_o, .flags_o);

// >>> sim/bdm_sfr_model.sv
`timescale 1ns/1ps
module bdm_sfr_model
   import bdm_pkg::*;
#(
   parameter logic [7:0] RD_VAL = 8'h5a
)
(
   // window from the block
   input  wire logic        core_clk_i,
   input  wire logic        sfr_wr_i,
   input  wire logic [11:0] sfr_addr_i,
   input  wire logic [7:0]  sfr_wdata_i,
   // answers
   output logic      [7:0]  sfr_rdata_o,
   output logic      [11:0] last_addr_o,
   output logic      [7:0]  last_data_o
);
   // fixed status byte, since the read is sampled before the address is out
   assign sfr_rdata_o = RD_VAL;
   // remember the last peripheral write
   always_ff @(posedge core_clk_i) begin
      if (sfr_wr_i) begin
         last_addr_o <= sfr_addr_i;
         last_data_o <= sfr_wdata_i;
      end
   end
endmodule

// >>> sim/test_bdm_core.sv
`timescale 1ns/1ps
module test_bdm_core
   import bdm_pkg::*;
;
   logic        core_clk_i  = 1'b0;
   logic        resetn_i    = 1'b0;
   bdm_req_s    req_i       = '0;
   logic        rst_upd_i   = 1'b0;
   logic [1:0]  rst_to_pd_i = 2'h0;
   logic [7:0]  sfr_rdata_i;
   logic        sfr_wr_o;
   logic        sfr_rd_o;
   logic        rvalid_o;
   logic [11:0] sfr_addr_o;
   logic [11:0] last_addr;
   logic [7:0]  sfr_wdata_o;
   logic [7:0]  rdata_o;
   logic [7:0]  bank_o;
   logic [7:0]  working_accumulator_o;
   logic [7:0]  flags_o;
   logic [7:0]  last_data;
   int          err_total   = 0;
   int          n_tests     = 0;
   // 40 MHz core clock
   always #12.5 core_clk_i = ~core_clk_i;
   bdm_core u_bdm_core (.core_clk_i, .resetn_i, .req_i, .rst_upd_i, .rst_to_pd_i, .sfr_rdata_i,
      .sfr_wr_o, .sfr_rd_o, .sfr_addr_o, .sfr_wdata_o, .rdata_o, .rvalid_o, .bank_o, .working_accumulator_o,
      .flags_o);
   bdm_sfr_model u_bdm_sfr_model (.core_clk_i, .sfr_wr_i(sfr_wr_o), .sfr_addr_i(sfr_addr_o),
      .sfr_wdata_i(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_i), .last_addr_o(last_addr),
      .last_data_o(last_data));
   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one request for one cycle; k = {rd,wr,clr}, a = {alu,z,dc,c}
   task automatic acc(input logic [2:0] k, input bdm_mode_e m, input logic [6:0] o,
                      input logic [7:0] d, input logic [3:0] a = 4'h0);
      @(posedge core_clk_i);
      req_i <= '{k[2], k[1], m, o, d, k[0], a[3], a[2:0]};
      @(posedge core_clk_i);
      req_i <= '0;
      #1;
   endtask
   task automatic wr(input logic [6:0] o, input logic [7:0] d);
      acc(3'b010, BDM_MODE_DIRECT, o, d);
   endtask
   task automatic rd(input bdm_mode_e m, input logic [6:0] o, input logic [7:0] e);
      acc(3'b100, m, o, 8'h00);
      chk(rvalid_o, 1'b1);
      chk(rdata_o, e);
   endtask
   task automatic end_of_test();
      if (err_total == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      #1;
      chk(flags_o, BDM_FLAGS_RST);
      wr(BDM_OFS_BANK, 8'hff);
      rd(BDM_MODE_DIRECT, BDM_OFS_BANK, 8'h1f);
      wr(7'h70, 8'ha5);
      wr(BDM_OFS_BANK, 8'h03);
      wr(7'h20, 8'h33);
      rd(BDM_MODE_DIRECT, 7'h70, 8'ha5);
      wr(BDM_OFS_BANK, 8'h00);
      wr(7'h20, 8'h11);
      rd(BDM_MODE_DIRECT, 7'h20, 8'h11);
      wr(BDM_OFS_BANK, 8'h03);
      rd(BDM_MODE_DIRECT, 7'h20, 8'h33);
      wr(BDM_OFS_BANK, 8'h05);
      wr(7'h20, 8'h77);
      rd(BDM_MODE_DIRECT, 7'h20, 8'h00);
      for (int i = 2; i < 12; i++) begin
         if (i != 3 && i != 8) wr(7'(i), 8'(i + 64));
      end
      wr(BDM_OFS_BANK, 8'h1d);
      for (int i = 2; i < 12; i++) begin
         if (i != 3 && i != 8) rd(BDM_MODE_DIRECT, 7'(i), 8'(i + 64));
      end
      chk(working_accumulator_o, 8'h49);
      wr(BDM_OFS_P0L, 8'h09);
      wr(BDM_OFS_P0H, 8'h00);
      rd(BDM_MODE_PTR0, 7'h00, 8'h49);
      wr(BDM_OFS_P1L, 8'ha0);
      wr(BDM_OFS_P1H, 8'h01);
      rd(BDM_MODE_PTR1, 7'h00, 8'h33);
      acc(3'b010, BDM_MODE_PTR1, 7'h00, 8'h44);
      wr(BDM_OFS_BANK, 8'h03);
      rd(BDM_MODE_DIRECT, 7'h20, 8'h44);
      wr(BDM_OFS_BANK, 8'h02);
      wr(BDM_OFS_SFR_LO, 8'h3c);
      @(posedge core_clk_i);
      #1;
      chk(last_addr, 12'h10c);
      chk(last_data, 8'h3c);
      rd(BDM_MODE_DIRECT, 7'h0d, 8'h5a);
      chk(bank_o, 8'h02);
      wr(BDM_OFS_FLAGS, 8'h00);
      rd(BDM_MODE_DIRECT, BDM_OFS_FLAGS, 8'h18);
      wr(BDM_OFS_FLAGS, 8'he7);
      rd(BDM_MODE_DIRECT, BDM_OFS_FLAGS, 8'hff);
      acc(3'b010, BDM_MODE_DIRECT, BDM_OFS_FLAGS, 8'h00, 4'hd);
      rd(BDM_MODE_DIRECT, BDM_OFS_FLAGS, 8'h1d);
      acc(3'b010, BDM_MODE_DIRECT, BDM_OFS_FLAGS, 8'h07, 4'h8);
      rd(BDM_MODE_DIRECT, BDM_OFS_FLAGS, 8'h18);
      wr(BDM_OFS_FLAGS, 8'he3);
      acc(3'b001, BDM_MODE_DIRECT, BDM_OFS_FLAGS, 8'h00);
      rd(BDM_MODE_DIRECT, BDM_OFS_FLAGS, 8'h1f);
      @(posedge core_clk_i);
      rst_upd_i   <= 1'b1;
      rst_to_pd_i <= 2'h2;
      @(posedge core_clk_i);
      rst_upd_i   <= 1'b0;
      rst_to_pd_i <= 2'h0;
      wr(BDM_OFS_FLAGS, 8'hff);
      rd(BDM_MODE_DIRECT, BDM_OFS_FLAGS, 8'hf7);
      chk(flags_o, 8'hf7);
      @(posedge core_clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      #1;
      chk(flags_o, BDM_FLAGS_RST);
      chk(bank_o, BDM_REG_RST);
      chk(working_accumulator_o, BDM_REG_RST);
      end_of_test();
   end
endmodule
